// ===== tap_pkg.sv
package tap_pkg;

  // SFR addresses of the registers in this bank.
  localparam logic [7:0] TAP_ADDR_POWER_CONTROL    = 8'h87;
  localparam logic [7:0] TAP_ADDR_EXTENDED_FLAGS   = 8'h91;
  localparam logic [7:0] TAP_ADDR_ACCESS_UNLOCK    = 8'hc7;
  localparam logic [7:0] TAP_ADDR_WATCHDOG_CONTROL = 8'hd8;

  // Unlock key bytes.
  localparam logic [7:0] TAP_KEY_FIRST  = 8'haa;
  localparam logic [7:0] TAP_KEY_SECOND = 8'h55;

  // Length of the unlock window in cycles.
  localparam logic [1:0] TAP_WINDOW_CYCLES = 2'h3;

  // Reset values.
  localparam logic [7:0] TAP_RST_POWER_CONTROL    = 8'h00;
  localparam logic [7:0] TAP_RST_EXTENDED_FLAGS   = 8'h00;
  localparam logic [7:0] TAP_RST_WATCHDOG_CONTROL = 8'h00;

  // Bit positions in power_control.
  localparam int TAP_PC_IDLE   = 0;
  localparam int TAP_PC_STOP   = 1;
  localparam int TAP_PC_GF_LO  = 2;
  localparam int TAP_PC_GF_HI  = 3;
  localparam int TAP_PC_FRAME_ERR   = 6;
  localparam int TAP_PC_SER0_DOUBLE = 7;

  // Bit positions in extended_flags.
  localparam int TAP_EF_BANDGAP_KEEP = 0;
  localparam int TAP_EF_RING_SELECT  = 1;
  localparam int TAP_EF_RING_STATUS  = 2;
  localparam int TAP_EF_UNUSED       = 3;
  localparam int TAP_EF_IRQ_LO       = 4;

  // Bit positions in watchdog_control.
  localparam int TAP_WD_RESTART     = 0;
  localparam int TAP_WD_RESET_EN    = 1;
  localparam int TAP_WD_RESET_FLAG  = 2;
  localparam int TAP_WD_IRQ_FLAG    = 3;
  localparam int TAP_WD_PF_FLAG     = 4;
  localparam int TAP_WD_PF_IRQ_EN   = 5;
  localparam int TAP_WD_POWER_ON    = 6;
  localparam int TAP_WD_SER1_DOUBLE = 7;

  // Protected bit masks per register.
  localparam logic [7:0] TAP_PROT_EXTENDED_FLAGS   = 8'h01;
  localparam logic [7:0] TAP_PROT_WATCHDOG_CONTROL = 8'h4b;
  // Writable (non-status) masks.
  localparam logic [7:0] TAP_WR_POWER_CONTROL    = 8'hcf;
  localparam logic [7:0] TAP_WR_EXTENDED_FLAGS   = 8'hf3;
  localparam logic [7:0] TAP_WR_WATCHDOG_CONTROL = 8'hff;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } tap_sfr_req_t;

  typedef struct packed {
    logic       por;
    logic       power_fail;
    logic       wdog_irq;
    logic       wdog_reset;
    logic       ring_mode;
    logic [3:0] ext_irq;
  } tap_event_t;

endpackage

// ===== tap_unlock.sv
`timescale 1ns/10ps
`default_nettype none
module tap_unlock
  import tap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       unlock_wr,
  input  wire logic [7:0] unlock_data,
  input  wire logic       prot_wr,
  output logic            window_open
);

  logic       armed;
  logic [1:0] left;
  wire        first_key  = unlock_wr && (unlock_data == TAP_KEY_FIRST);
  wire        second_key = unlock_wr && (unlock_data == TAP_KEY_SECOND) && armed;

  // The second key must come in the cycle right after the first; any cycle between the keys breaks the pair.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else
      armed <= first_key;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      left <= 2'h0;
    else if (second_key)
      left <= TAP_WINDOW_CYCLES;
    else if (prot_wr)
      left <= 2'h0;
    else if (left != 2'h0)
      left <= left - 2'h1;
  end

  assign window_open = (left != 2'h0);

endmodule
`default_nettype wire

// ===== tap_sfr_bank.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - By default the bandgap reference switches off in Stop; power-fail detect inactive.
// - Keep-on select set keeps bandgap in Stop; an enabled power-fail interrupt can wake.
// - Keep-on select is bit 0 of extended_flags at 91h, reset to zero.
// - Keep-on select affects the reference only in Stop, not in run or Idle.
// - Writing AAh then 55h to C7h opens a three-cycle window for one write to a register with protected bits.
// - Protected bit writes outside the unlock window are ignored; old value kept.
// - Protected bits: bandgap select, power-on flag, watchdog flag, reset enable, restart.
// - power_control at 87h: Idle bit0, Stop bit1, flags bits2-3, serial bits6-7.
// - watchdog_control at D8h: baud double, power and watchdog flags, enables, restart.
// - Stop is left on an external wake, an enabled power-fail interrupt, a write to 87h with bit1 clear or a reset.
module tap_sfr_bank
  import tap_pkg::*;
(
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_I,
  // SFR access from the core
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  output logic      [7:0] SFR_RDATA_O,
  // Hardware events that set status flags or wake the core
  input  wire logic       POR_EVENT_I,
  input  wire logic       POWER_FAIL_I,
  input  wire logic       WDOG_IRQ_I,
  input  wire logic       WDOG_RESET_I,
  input  wire logic       RING_MODE_I,
  input  wire logic [3:0] EXT_IRQ_I,
  input  wire logic       EXT_WAKE_I,
  // Power state and controls
  output logic            IDLE_O,
  output logic            STOP_O,
  output logic            BANDGAP_ON_O,
  output logic            PF_DETECT_ON_O,
  output logic            WAKE_O,
  output logic      [7:0] POWER_CONTROL_O,
  output logic      [7:0] EXTENDED_FLAGS_O,
  output logic      [7:0] WATCHDOG_CONTROL_O
);

  tap_sfr_req_t req;
  tap_event_t   ev;
  logic [7:0]   power_control;
  logic [7:0]   extended_flags;
  logic [7:0]   watchdog_control;
  logic [7:0]   next_power_control;
  logic [7:0]   next_extended_flags;
  logic [7:0]   next_watchdog_control;
  logic         window_open;

  assign req = '{wr: SFR_WR_I, rd: SFR_RD_I, addr: SFR_ADDR_I, data: SFR_WDATA_I};
  assign ev  = '{por: POR_EVENT_I, power_fail: POWER_FAIL_I, wdog_irq: WDOG_IRQ_I,
                 wdog_reset: WDOG_RESET_I, ring_mode: RING_MODE_I, ext_irq: EXT_IRQ_I};

  function automatic logic hit(input tap_sfr_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // Writes the new value into writable bits; protected bits only pass while unlocked.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] wmask, input logic [7:0] pmask,
                                       input logic open);
    logic [7:0] m;
    m = open ? wmask : (wmask & ~pmask);
    merge = (old & ~m) | (wd & m);
  endfunction

  wire wr_pc     = hit(req, TAP_ADDR_POWER_CONTROL);
  wire wr_ef     = hit(req, TAP_ADDR_EXTENDED_FLAGS);
  wire wr_wd     = hit(req, TAP_ADDR_WATCHDOG_CONTROL);
  wire wr_unlock = hit(req, TAP_ADDR_ACCESS_UNLOCK);
  // Any write touching a register that holds protected bits uses up the window.
  wire prot_wr   = (wr_ef || wr_wd) && window_open;

  tap_unlock u_unlock (
    .clk         (REF_CLK_I),
    .rst         (RST_I),
    .unlock_wr   (wr_unlock),
    .unlock_data (req.data),
    .prot_wr     (prot_wr),
    .window_open (window_open)
  );

  wire [7:0] ef_written = merge(extended_flags, req.data, TAP_WR_EXTENDED_FLAGS,
                                TAP_PROT_EXTENDED_FLAGS, window_open);
  wire [7:0] wd_written = merge(watchdog_control, req.data, TAP_WR_WATCHDOG_CONTROL,
                                TAP_PROT_WATCHDOG_CONTROL, window_open);

  // Flags set by hardware win over a software clear in the same cycle.
  wire [7:0] ef_set = {ev.ext_irq, 4'h0};
  wire [7:0] wd_set = {1'b0, ev.por, 1'b0, ev.power_fail, ev.wdog_irq, ev.wdog_reset, 2'b00};
  wire       in_stop = power_control[TAP_PC_STOP];
  // An external wake or an enabled power-fail ends Stop; Idle ends on an external wake or any external irq.
  wire       pf_wake = PF_DETECT_ON_O && ev.power_fail && watchdog_control[TAP_WD_PF_IRQ_EN];
  wire       wake    = in_stop && (EXT_WAKE_I || pf_wake);

  always_comb
  begin
    next_power_control = wr_pc ? (req.data & TAP_WR_POWER_CONTROL) : power_control;
    if (wake)
      next_power_control[TAP_PC_STOP] = 1'b0;
    if (power_control[TAP_PC_IDLE] && (EXT_WAKE_I || (|ev.ext_irq)))
      next_power_control[TAP_PC_IDLE] = 1'b0;
  end

  always_comb
  begin
    next_extended_flags = (wr_ef ? ef_written : extended_flags) | ef_set;
    next_extended_flags[TAP_EF_RING_STATUS] = ev.ring_mode;
    next_extended_flags[TAP_EF_UNUSED] = 1'b0;
  end

  always_comb
  begin
    next_watchdog_control = (wr_wd ? wd_written : watchdog_control) | wd_set;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      power_control    <= TAP_RST_POWER_CONTROL;
      extended_flags   <= TAP_RST_EXTENDED_FLAGS;
      watchdog_control <= TAP_RST_WATCHDOG_CONTROL;
    end
    else
    begin
      power_control    <= next_power_control;
      extended_flags   <= next_extended_flags;
      watchdog_control <= next_watchdog_control;
    end
  end

  wire [7:0] rd_mux = (SFR_ADDR_I == TAP_ADDR_POWER_CONTROL)    ? next_power_control :
                      (SFR_ADDR_I == TAP_ADDR_EXTENDED_FLAGS)   ? next_extended_flags :
                      (SFR_ADDR_I == TAP_ADDR_WATCHDOG_CONTROL) ? next_watchdog_control :
                      8'h00;
  // The unlock register reads as zero so the keys cannot be snooped back.
  wire next_stop  = next_power_control[TAP_PC_STOP];
  // Outside Stop the reference always runs; in Stop only the keep-on select holds it.
  wire next_bg_on = !next_stop || next_extended_flags[TAP_EF_BANDGAP_KEEP];

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      SFR_RDATA_O        <= 8'h00;
      IDLE_O             <= 1'b0;
      STOP_O             <= 1'b0;
      BANDGAP_ON_O       <= 1'b1;
      PF_DETECT_ON_O     <= 1'b1;
      WAKE_O             <= 1'b0;
      POWER_CONTROL_O    <= TAP_RST_POWER_CONTROL;
      EXTENDED_FLAGS_O   <= TAP_RST_EXTENDED_FLAGS;
      WATCHDOG_CONTROL_O <= TAP_RST_WATCHDOG_CONTROL;
    end
    else
    begin
      SFR_RDATA_O        <= req.rd ? rd_mux : 8'h00;
      IDLE_O             <= next_power_control[TAP_PC_IDLE];
      STOP_O             <= next_stop;
      BANDGAP_ON_O       <= next_bg_on;
      PF_DETECT_ON_O     <= next_bg_on;
      WAKE_O             <= wake;
      POWER_CONTROL_O    <= next_power_control;
      EXTENDED_FLAGS_O   <= next_extended_flags;
      WATCHDOG_CONTROL_O <= next_watchdog_control;
    end
  end

endmodule
`default_nettype wire

// ===== tap_sfr_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tap_sfr_bank_properties (
  // Clock, reset and core access
  input wire logic       REF_CLK_I,
  input wire logic       RST_I,
  input wire logic       SFR_WR_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  // Events and state
  input wire logic       POWER_FAIL_I,
  input wire logic       EXT_WAKE_I,
  input wire logic       STOP_O,
  input wire logic       BANDGAP_ON_O,
  input wire logic [7:0] POWER_CONTROL_O,
  input wire logic [7:0] EXTENDED_FLAGS_O
);
  // Age of the last second key byte; it saturates so a stale key never looks fresh.
  logic [2:0] age;
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      age <= 3'h7;
    else if (SFR_WR_I && SFR_ADDR_I == 8'hc7 && SFR_WDATA_I == 8'h55)
      age <= 3'h1;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  AST_BG_OFF: assert property ((STOP_O && !EXTENDED_FLAGS_O[0])[*2] |-> !BANDGAP_ON_O)
    else $error("bandgap on in stop");
  AST_BG_KEEP: assert property ((STOP_O && EXTENDED_FLAGS_O[0])[*2] |-> BANDGAP_ON_O)
    else $error("bandgap off despite keep");
  AST_BG_RUN: assert property ((!STOP_O)[*2] |-> BANDGAP_ON_O)
    else $error("bandgap off outside stop");
  AST_LOCKED: assert property (SFR_WR_I && SFR_ADDR_I == 8'h91 && age > 3'h3 |=>
    $stable(EXTENDED_FLAGS_O[0])) else $error("locked bit changed");
  AST_PC_WR: assert property (SFR_WR_I && SFR_ADDR_I == 8'h87 |=>
    (POWER_CONTROL_O & 8'hcc) == ($past(SFR_WDATA_I) & 8'hcc)) else $error("pc write lost");
  AST_RSVD: assert property (!EXTENDED_FLAGS_O[3] && POWER_CONTROL_O[5:4] == 2'h0)
    else $error("unused bit set");
  AST_STOP_HOLD: assert property (STOP_O && !EXT_WAKE_I && !POWER_FAIL_I && !SFR_WR_I
    |=> STOP_O) else $error("stop left without wake");
  AST_WAKE: assert property (STOP_O && EXT_WAKE_I |-> ##[1:2] !STOP_O)
    else $error("stop kept after wake");
endmodule
`default_nettype wire

// ===== tap_sfr_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tap_sfr_bank_tb;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       wr   = 1'b0;
  logic       rd   = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [3:0] ev   = 4'h0;
  logic       ring = 1'b0;
  logic [3:0] eirq = 4'h0;
  logic       wake = 1'b0;
  logic [7:0] rdat, pc, ef, wdc, exp_v;
  logic       stop, bg;
  logic       idle, pfd, wk;
  logic [7:0] seed = 8'h5c;
  logic [7:0] pb [3] = '{8'h40, 8'h08, 8'h02};
  int         miscompares = 0;
  int         num_checks = 0;
  always #25 clk = ~clk;
  tap_sfr_bank dut (.REF_CLK_I(clk), .RST_I(rst), .SFR_WR_I(wr), .SFR_RD_I(rd),
    .SFR_ADDR_I(addr), .SFR_WDATA_I(wdat), .SFR_RDATA_O(rdat), .POR_EVENT_I(ev[3]),
    .POWER_FAIL_I(ev[2]), .WDOG_IRQ_I(ev[1]), .WDOG_RESET_I(ev[0]), .RING_MODE_I(ring),
    .EXT_IRQ_I(eirq), .EXT_WAKE_I(wake), .IDLE_O(idle), .STOP_O(stop), .BANDGAP_ON_O(bg),
    .PF_DETECT_ON_O(pfd), .WAKE_O(wk), .POWER_CONTROL_O(pc), .EXTENDED_FLAGS_O(ef),
    .WATCHDOG_CONTROL_O(wdc));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdat = d;
    @(posedge clk);
    #1;
  endtask
  task automatic gap(input int n);
    wr = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    wr = 1'b0;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk("rdata", e, rdat);
  endtask
  task automatic unl();
    w(8'hc7, 8'haa);
    w(8'hc7, 8'h55);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("rst", 8'h00, pc | ef | wdc);
    chk("rstbg", 8'h03, {6'h00, bg, pfd});
    w(8'h91, 8'hf3);
    w(8'hd8, 8'hff);
    gap(1);
    chk("ef", 8'hf2, ef);
    chk("wdc", 8'hb4, wdc);
    w(8'h91, 8'h00);
    w(8'hd8, 8'h00);
    exp_v = 8'h00;
    // The last pass waits one cycle too long, so that write must be dropped.
    for (int k = 0; k < 4; k++)
    begin
      unl();
      if (k > 0)
        gap(k);
      w(8'h91, {7'h00, ~exp_v[0]});
      if (k < 3)
        exp_v[0] = ~exp_v[0];
      gap(1);
      chk("ef", exp_v, ef);
    end
    unl();
    w(8'hd8, 8'h01);
    w(8'hd8, 8'h02);
    gap(1);
    chk("wdc", 8'h01, wdc);
    w(8'hc7, 8'haa);
    gap(1);
    w(8'hc7, 8'h55);
    w(8'hd8, 8'h03);
    gap(1);
    chk("wdc", 8'h01, wdc);
    exp_v = 8'h01;
    for (int i = 0; i < 3; i++)
    begin
      exp_v = exp_v | pb[i];
      unl();
      w(8'hd8, exp_v);
      gap(1);
      chk("wdc", exp_v, wdc);
    end
    w(8'hd8, 8'h20);
    w(8'h87, 8'h02);
    gap(2);
    chk("keep", 8'h01, {7'h00, bg});
    chk("pfdkeep", 8'h01, {7'h00, pfd});
    ev = 4'h4;
    gap(1);
    chk("pfwakepulse", 8'h01, {7'h00, wk});
    ev = 4'h0;
    gap(1);
    chk("pfwake", 8'h00, {7'h00, stop});
    unl();
    w(8'h91, 8'h00);
    w(8'h87, 8'h02);
    gap(2);
    chk("bgoff", 8'h00, {7'h00, bg});
    chk("pfdoff", 8'h00, {7'h00, pfd});
    ev = 4'h6;
    gap(1);
    ev = 4'h0;
    chk("nowake", 8'h01, {7'h00, stop});
    wake = 1'b1;
    gap(1);
    chk("wakepulse", 8'h01, {7'h00, wk});
    wake = 1'b0;
    gap(1);
    chk("wake", 8'h00, {7'h00, stop});
    w(8'h87, 8'h01);
    gap(1);
    chk("idle", 8'h03, {6'h00, idle, bg});
    wake = 1'b1;
    gap(1);
    wake = 1'b0;
    chk("idleexit", 8'h00, {6'h00, idle, wk});
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      w(8'h87, seed & 8'hcc);
      r(8'h87, seed & 8'hcc);
    end
    r(8'h90, 8'h00);
    rst = 1'b1;
    gap(2);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      ev = 4'h1 << i;
      gap(1);
    end
    ev = 4'h0;
    chk("wdc", 8'h5c, wdc);
    seed = lfsr(seed);
    eirq = seed[3:0];
    ring = seed[4];
    gap(1);
    chk("ef", {seed[3:0], 1'b0, seed[4], 2'b00}, ef);
    results();
  end
endmodule
bind tap_sfr_bank tap_sfr_bank_properties u_props (.REF_CLK_I, .RST_I, .SFR_WR_I,
  .SFR_ADDR_I, .SFR_WDATA_I, .POWER_FAIL_I, .EXT_WAKE_I, .STOP_O, .BANDGAP_ON_O,
  .POWER_CONTROL_O, .EXTENDED_FLAGS_O);
`default_nettype wire
